// ---- smbs_bus_model.sv ----
// Far-side SMBus device model that drives the clock and data pins as open-drain lines.
`timescale 1ns/1ps
`default_nettype none
module smbs_bus_model (
    output var logic smb_scl,
    output var logic smb_sda
);
    localparam realtime HALF = 62.5;

    logic scl_oe;
    logic sda_oe;

    // Pull-ups hold each line high whenever nobody pulls it low.
    assign smb_scl = ~scl_oe;
    assign smb_sda = ~sda_oe;

    // Both lines are released while the bus is idle.
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    // A start pulls data low while the clock is high, then pulls the clock low.
    task automatic put_start();
        // A small skew keeps every later pin change away from the core clock edges.
        #1.25;
        sda_oe = 1'b0;
        scl_oe = 1'b0;
        #HALF;
        sda_oe = 1'b1;
        #HALF;
        scl_oe = 1'b1;
        #HALF;
    endtask

    // Data changes only while the clock is low, and holds across the high phase.
    task automatic put_bit(input logic b);
        sda_oe = ~b;
        #HALF;
        scl_oe = 1'b0;
        #HALF;
        scl_oe = 1'b1;
    endtask

    // A stop releases data while the clock is high and leaves both lines idle.
    task automatic put_stop();
        sda_oe = 1'b1;
        #HALF;
        scl_oe = 1'b0;
        #HALF;
        sda_oe = 1'b0;
        #HALF;
    endtask

    // Eight data bits go out most significant first, then the acknowledge bit.
    task automatic put_byte(input logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(v[i]);
        end
        put_bit(~ack);
    endtask
endmodule
`default_nettype wire

// ---- smbs_flag_if.sv ----
// Set, clear and state of a bank of sticky flags.
`timescale 1ns/1ps
`default_nettype none
interface smbs_flag_if #(parameter int W = 32);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (output set, output clr, input q);
    modport store (input set, input clr, output q);
endinterface
`default_nettype wire

// ---- smbs_map.svh ----
// Register offsets, field positions, reset values and link counts of the SMBus status block.
`ifndef SMBS_MAP_SVH
`define SMBS_MAP_SVH

`define SMBS_ADDR_W        12
`define SMBS_OFF_STATUS    12'hAC8
`define SMBS_OFF_IRQ_STS   12'hB00
`define SMBS_OFF_IRQ_CLR   12'hB04
`define SMBS_OFF_IRQ_EN    12'hB08

`define SMBS_TGT_LSB       1
`define SMBS_TGT_MSB       7
`define SMBS_INI_LSB       9
`define SMBS_INI_MSB       15
`define SMBS_BLANK_BIT     22
`define SMBS_ROLL_BIT      23
`define SMBS_DONE_BIT      24
`define SMBS_NACK_BIT      25
`define SMBS_MISP_BIT      27
`define SMBS_CKSUM_BIT     28

`define SMBS_STATUS_RST    32'h0000_0000
`define SMBS_IRQ_EN_RST    32'h0000_0000
`define SMBS_ERR_MASK      32'h1AC0_0000
`define SMBS_EVT_MASK      32'h1BC0_0000
`define SMBS_RSVD_MASK     32'hE43F_0101
`define SMBS_ACK_EDGE      4'h9

`endif

// ---- smbs_pkg.sv ----
// Types shared by the SMBus status block.
package smbs_pkg;
    typedef logic [31:0] smbs_word_t;
    typedef enum logic [0:0] {SMBS_LINK_IDLE, SMBS_LINK_FRAME} smbs_link_t;
endpackage

// ---- smbs_status_top.sv ----
// SMBus and serial EEPROM status register with APB access, link watcher and interrupt.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "smbs_map.svh"

module smbs_status_top
    import smbs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic            pready,
    output logic            pslverr,
    input  wire logic [6:0] target_port_bus_address_strap,
    input  wire logic [6:0] initiator_port_bus_address_strap,
    input  wire logic       rom_load_mode,
    input  wire logic       rom_blank_evt,
    input  wire logic       rom_dword_count_bad_evt,
    input  wire logic       rom_done_seq_bad_evt,
    input  wire logic       rom_rollover_evt,
    input  wire logic       rom_cksum_bad_evt,
    input  wire logic       rom_no_done_cmd_evt,
    input  wire logic       rom_load_finish_evt,
    input  wire logic       master_active,
    input  wire logic       master_ack_check,
    input  wire logic       smb_scl,
    input  wire logic       smb_sda,
    output logic            irq
);
    // Bus answer registers.
    smbs_word_t prdata_r;
    logic       pready_r;
    logic       pslverr_r;
    logic       irq_r;

    // Hardware-initialised addresses.
    logic [6:0] tgt_addr_r;
    logic [6:0] ini_addr_r;
    logic       init_done_r;

    // Load-complete bit and interrupt enable.
    logic       done_r;
    smbs_word_t irq_en_r;

    // Link watcher state.
    logic [1:0] line_s;
    logic [1:0] line_prev_r;
    smbs_link_t link_r;
    logic [3:0] bit_cnt_r;
    logic       nack_evt;
    logic       misp_evt;
    logic       scl_rise;
    logic       start_cond;
    logic       stop_cond;

    // Decode and event vectors.
    logic       acc;
    logic       wr_fire;
    logic       hit_sts;
    logic       hit_isr;
    logic       hit_icl;
    logic       hit_ien;
    logic       mapped;
    smbs_word_t evt_vec;
    smbs_word_t status_word;
    smbs_word_t rd_nxt;

    smbs_flag_if #(.W(32)) flag_bus ();
    smbs_flag_if #(.W(32)) isr_bus ();

    // Flags of the status register.
    smbs_sticky #(.W(32)) u_flags (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .f       (flag_bus)
    );

    // Interrupt status bits, same layout as the status register.
    smbs_sticky #(.W(32)) u_isr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .f       (isr_bus)
    );

    // Bus clock and data from the pins enter the core domain here.
    smbs_sync #(.W(2), .RST(2'h3)) u_line_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .d       ({smb_scl, smb_sda}),
        .q       (line_s)
    );

    // Address decode; an access is answered one cycle after it enters its access phase.
    assign acc     = psel & penable & ~pready_r;
    assign wr_fire = psel & penable & pready_r & pwrite;
    assign hit_sts = (paddr == `SMBS_OFF_STATUS);
    assign hit_isr = (paddr == `SMBS_OFF_IRQ_STS);
    assign hit_icl = (paddr == `SMBS_OFF_IRQ_CLR);
    assign hit_ien = (paddr == `SMBS_OFF_IRQ_EN);
    assign mapped  = hit_sts | hit_isr | hit_icl | hit_ien;

    // Addresses are taken from the straps at the first enabled edge after reset release.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tgt_addr_r  <= 7'h00;
            ini_addr_r  <= 7'h00;
            init_done_r <= 1'b0;
        end else if (ce && !init_done_r) begin
            tgt_addr_r  <= target_port_bus_address_strap;
            ini_addr_r  <= initiator_port_bus_address_strap;
            init_done_r <= 1'b1;
        end
    end

    // Edges and conditions on the synchronised bus lines.
    assign scl_rise   = line_s[1] & ~line_prev_r[1];
    assign start_cond = line_s[1] & line_prev_r[1] & line_prev_r[0] & ~line_s[0];
    assign stop_cond  = line_s[1] & line_prev_r[1] & ~line_prev_r[0] & line_s[0];

    // A missing acknowledge at the ninth clock of a byte is an error when the master expects one.
    assign nack_evt = master_active & master_ack_check & scl_rise & line_s[0]
                      & (link_r == SMBS_LINK_FRAME) & (bit_cnt_r == `SMBS_ACK_EDGE - 4'h1);

    // A condition inside a byte of a master transaction is misplaced. The clock rise that
    // precedes a proper STOP or repeated START counts as one, so only a count above one is wrong.
    assign misp_evt = master_active & (start_cond | stop_cond) & (link_r == SMBS_LINK_FRAME)
                      & (bit_cnt_r > 4'h1);

    // Frame tracker counts clock rises between conditions, nine to a byte.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            line_prev_r <= 2'h3;
            link_r      <= SMBS_LINK_IDLE;
            bit_cnt_r   <= 4'h0;
        end else if (ce) begin
            line_prev_r <= line_s;
            if (start_cond) begin
                link_r    <= SMBS_LINK_FRAME;
                bit_cnt_r <= 4'h0;
            end else if (stop_cond) begin
                link_r    <= SMBS_LINK_IDLE;
                bit_cnt_r <= 4'h0;
            end else if (scl_rise && link_r == SMBS_LINK_FRAME) begin
                if (bit_cnt_r == `SMBS_ACK_EDGE - 4'h1) begin
                    bit_cnt_r <= 4'h0;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
            end
        end
    end

    // Hardware events, placed at their status bit positions.
    always_comb begin
        evt_vec = '0;
        evt_vec[`SMBS_BLANK_BIT] = rom_load_mode
                                   & (rom_blank_evt | rom_dword_count_bad_evt | rom_done_seq_bad_evt);
        evt_vec[`SMBS_ROLL_BIT]  = rom_load_mode & rom_rollover_evt;
        evt_vec[`SMBS_DONE_BIT]  = rom_load_mode & rom_load_finish_evt & ~done_r;
        evt_vec[`SMBS_NACK_BIT]  = nack_evt;
        evt_vec[`SMBS_MISP_BIT]  = misp_evt;
        evt_vec[`SMBS_CKSUM_BIT] = rom_cksum_bad_evt | rom_no_done_cmd_evt;
    end

    // Error flags take sets from hardware and one-writes from software.
    assign flag_bus.set = evt_vec & `SMBS_ERR_MASK;
    assign flag_bus.clr = (wr_fire && hit_sts) ? (pwdata & `SMBS_ERR_MASK) : '0;

    // Interrupt status takes every event and clears through the clear register.
    assign isr_bus.set = evt_vec & `SMBS_EVT_MASK;
    assign isr_bus.clr = (wr_fire && hit_icl) ? (pwdata & `SMBS_EVT_MASK) : '0;

    // The load-complete bit is read-only and leaves only by reset.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else if (ce && evt_vec[`SMBS_DONE_BIT]) begin
            done_r <= 1'b1;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq_en_r <= `SMBS_IRQ_EN_RST;
        end else if (ce && wr_fire && hit_ien) begin
            irq_en_r <= pwdata & `SMBS_EVT_MASK;
        end
    end

    // Status word; reserved positions are forced to zero.
    always_comb begin
        status_word = flag_bus.q & `SMBS_ERR_MASK;
        status_word[`SMBS_TGT_MSB:`SMBS_TGT_LSB] = tgt_addr_r;
        status_word[`SMBS_INI_MSB:`SMBS_INI_LSB] = ini_addr_r;
        status_word[`SMBS_DONE_BIT] = done_r;
        status_word = status_word & ~`SMBS_RSVD_MASK;
    end

    // Read data mux; the clear register and unmapped addresses read as zero.
    always_comb begin
        rd_nxt = '0;
        if (hit_sts) begin
            rd_nxt = status_word;
        end else if (hit_isr) begin
            rd_nxt = isr_bus.q & `SMBS_EVT_MASK;
        end else if (hit_ien) begin
            rd_nxt = irq_en_r;
        end
    end

    // APB answer: ready for one cycle, error on an unmapped address.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else if (ce) begin
            pready_r  <= acc;
            pslverr_r <= acc & ~mapped;
            if (acc && !pwrite) begin
                prdata_r <= rd_nxt;
            end else if (acc) begin
                prdata_r <= '0;
            end
        end
    end

    // Level interrupt while any enabled status bit is set.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(isr_bus.q & irq_en_r);
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // Checks on the logic above.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_tgt_addr;
        pready_r && $past(hit_sts) && $past(!pwrite) |-> prdata_r[7:1] == tgt_addr_r;
    endproperty
    a_tgt_addr: assert property (p_tgt_addr) else $error("slave address field wrong");

    property p_ini_addr;
        pready_r && $past(hit_sts) && $past(!pwrite) |-> prdata_r[15:9] == ini_addr_r;
    endproperty
    a_ini_addr: assert property (p_ini_addr) else $error("master address field wrong");

    property p_blank;
        ce && rom_load_mode && (rom_blank_evt || rom_dword_count_bad_evt || rom_done_seq_bad_evt)
            |=> flag_bus.q[22];
    endproperty
    a_blank: assert property (p_blank) else $error("blank flag not set");

    property p_blank_mode;
        ce && !rom_load_mode && !flag_bus.q[22] |=> !flag_bus.q[22];
    endproperty
    a_blank_mode: assert property (p_blank_mode) else $error("blank flag set outside load mode");

    property p_roll;
        ce && rom_load_mode && rom_rollover_evt |=> flag_bus.q[23];
    endproperty
    a_roll: assert property (p_roll) else $error("rollover flag not set");

    property p_done;
        ce && rom_load_mode && rom_load_finish_evt |=> done_r ##1 done_r;
    endproperty
    a_done: assert property (p_done) else $error("load complete not held");

    property p_nack;
        ce && nack_evt |=> flag_bus.q[25] && isr_bus.q[25];
    endproperty
    a_nack: assert property (p_nack) else $error("nack flag not set");

    property p_misp;
        ce && master_active && stop_cond && link_r == SMBS_LINK_FRAME && bit_cnt_r > 4'h1
            |=> flag_bus.q[27];
    endproperty
    a_misp: assert property (p_misp) else $error("misplaced condition flag not set");

    property p_cksum;
        ce && (rom_cksum_bad_evt || rom_no_done_cmd_evt) |=> flag_bus.q[28];
    endproperty
    a_cksum: assert property (p_cksum) else $error("checksum flag not set");

    property p_hold;
        ce && flag_bus.q[25] && !(wr_fire && hit_sts && pwdata[25]) |=> flag_bus.q[25];
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without a clear");

    property p_rsvd;
        pready_r |-> (prdata_r & `SMBS_RSVD_MASK) == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

    property p_irq;
        ce && |(isr_bus.q & irq_en_r) |=> irq_r;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_misp_legal;
        ce && (start_cond || stop_cond) && bit_cnt_r <= 4'h1 && !flag_bus.q[27] |=> !flag_bus.q[27];
    endproperty
    a_misp_legal: assert property (p_misp_legal) else $error("proper condition flagged");

    property p_done_ro;
        done_r |=> done_r;
    endproperty
    a_done_ro: assert property (p_done_ro) else $error("load complete bit dropped");

    c_status_read: cover property (pready_r && $past(hit_sts) && $past(!pwrite));
    c_nack_seen:   cover property (nack_evt);
    c_clear_flag:  cover property (flag_bus.q[22] && wr_fire && hit_sts && pwdata[22]);
    c_irq_high:    cover property ($rose(irq_r));
endmodule
`default_nettype wire

// ---- smbs_status_top_test.sv ----
// Self-checking bench for the SMBus status block through APB and the bus pins.
`timescale 1ns/1ps
`default_nettype none
`include "smbs_map.svh"
module smbs_status_top_test
    import smbs_pkg::*;
();
    localparam logic [6:0] TGT = 7'h5A;
    localparam logic [6:0] INI = 7'h33;
    localparam int EBIT [7] = '{22, 22, 22, 23, 28, 28, 24};

    logic        sys_clk;
    logic        nrst;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    smbs_word_t  pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [6:0]  evt;
    logic        rom_load_mode;
    logic        master_active;
    logic        master_ack_check;
    logic        smb_scl;
    logic        smb_sda;
    int          error_cnt;
    int          n_checks;
    smbs_word_t  q;
    smbs_word_t  base;
    logic        e;

    smbs_status_top dut (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .target_port_bus_address_strap(TGT), .initiator_port_bus_address_strap(INI),
        .rom_load_mode(rom_load_mode), .rom_blank_evt(evt[0]), .rom_dword_count_bad_evt(evt[1]),
        .rom_done_seq_bad_evt(evt[2]), .rom_rollover_evt(evt[3]), .rom_cksum_bad_evt(evt[4]),
        .rom_no_done_cmd_evt(evt[5]), .rom_load_finish_evt(evt[6]), .master_active(master_active),
        .master_ack_check(master_ack_check), .smb_scl(smb_scl), .smb_sda(smb_sda), .irq(irq)
    );

    smbs_bus_model bus (.smb_scl(smb_scl), .smb_sda(smb_sda));

    // The core clock runs at 125 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compares a value with its expectation and counts the outcome.
    task automatic chk(input smbs_word_t got, input smbs_word_t exp);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input smbs_word_t d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a, input smbs_word_t exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic wr(input logic [11:0] a, input smbs_word_t d);
        apb(1'b1, a, d);
    endtask

    // Raises one event input for a single cycle.
    task automatic pulse(input int i);
        evt <= 7'h01 << i;
        @(posedge sys_clk);
        evt <= 7'h00;
        @(posedge sys_clk);
    endtask

    // Sends one whole frame, then lets the pin synchroniser catch up.
    task automatic frame(input logic [7:0] v, input logic ack);
        bus.put_start();
        bus.put_byte(v, ack);
        bus.put_stop();
        @(posedge sys_clk);
        repeat (10) @(posedge sys_clk);
    endtask

    // Main sequence of tests.
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        evt = 7'h00;
        rom_load_mode = 1'b0;
        master_active = 1'b0;
        master_ack_check = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        base = {16'h0000, INI, 1'b0, TGT, 1'b0};
        rd(`SMBS_OFF_STATUS, base);
        wr(`SMBS_OFF_STATUS, 32'hFFFF_FFFF);
        rd(`SMBS_OFF_STATUS, base);
        $display("test reset_and_reserved done");
        rom_load_mode <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            rd(`SMBS_OFF_STATUS, base | (32'h1 << EBIT[i]));
            wr(`SMBS_OFF_STATUS, 32'h0000_0000);
            rd(`SMBS_OFF_STATUS, base | (32'h1 << EBIT[i]));
            wr(`SMBS_OFF_STATUS, 32'h1 << EBIT[i]);
            if (i == 6) begin
                base = base | (32'h1 << `SMBS_DONE_BIT);
            end
            rd(`SMBS_OFF_STATUS, base);
        end
        // A new blank event lands on the very edge of the clearing write.
        pulse(0);
        fork
            wr(`SMBS_OFF_STATUS, 32'h1 << `SMBS_BLANK_BIT);
            begin
                for (int k = 0; k < 8 && !(psel && penable); k++) @(posedge sys_clk);
                evt <= 7'h01;
                @(posedge sys_clk);
                evt <= 7'h00;
            end
        join
        rd(`SMBS_OFF_STATUS, base | (32'h1 << `SMBS_BLANK_BIT));
        wr(`SMBS_OFF_STATUS, 32'h1 << `SMBS_BLANK_BIT);
        rom_load_mode <= 1'b0;
        pulse(0);
        pulse(3);
        rd(`SMBS_OFF_STATUS, base);
        $display("test rom_flags done");
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk({31'h0, e}, 32'h1);
        wr(`SMBS_OFF_IRQ_CLR, 32'hFFFF_FFFF);
        wr(`SMBS_OFF_IRQ_EN, 32'h1 << `SMBS_NACK_BIT);
        rd(`SMBS_OFF_IRQ_STS, 32'h0000_0000);
        rd(`SMBS_OFF_IRQ_EN, 32'h1 << `SMBS_NACK_BIT);
        rd(`SMBS_OFF_IRQ_CLR, 32'h0000_0000);
        chk({31'h0, e}, 32'h0);
        $display("test access_refusal done");
        master_active <= 1'b1;
        master_ack_check <= 1'b1;
        frame(8'hA5, 1'b1);
        rd(`SMBS_OFF_STATUS, base);
        frame(8'h5A, 1'b0);
        rd(`SMBS_OFF_STATUS, base | (32'h1 << `SMBS_NACK_BIT));
        chk({31'h0, irq}, 32'h1);
        rd(`SMBS_OFF_IRQ_STS, 32'h1 << `SMBS_NACK_BIT);
        wr(`SMBS_OFF_IRQ_EN, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        wr(`SMBS_OFF_IRQ_CLR, 32'h1 << `SMBS_NACK_BIT);
        wr(`SMBS_OFF_STATUS, 32'h1 << `SMBS_NACK_BIT);
        rd(`SMBS_OFF_IRQ_STS, 32'h0000_0000);
        master_active <= 1'b0;
        frame(8'h5A, 1'b0);
        rd(`SMBS_OFF_STATUS, base);
        master_active <= 1'b1;
        bus.put_start();
        repeat (3) bus.put_bit(1'b1);
        bus.put_stop();
        @(posedge sys_clk);
        repeat (10) @(posedge sys_clk);
        rd(`SMBS_OFF_STATUS, base | (32'h1 << `SMBS_MISP_BIT));
        wr(`SMBS_OFF_STATUS, 32'h1 << `SMBS_MISP_BIT);
        rd(`SMBS_OFF_STATUS, base);
        $display("test link_errors done");
        // With the clock enable low an event pulse must leave no trace.
        ce <= 1'b0;
        pulse(4);
        ce <= 1'b1;
        rd(`SMBS_OFF_STATUS, base);
        $display("test clock_enable done");
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- smbs_sticky.sv ----
// Bank of sticky flags in which a set beats a simultaneous clear.
`timescale 1ns/1ps
`default_nettype none
module smbs_sticky #(
    parameter int W = 32
) (
    input  wire logic   sys_clk,
    input  wire logic   nrst,
    input  wire logic   ce,
    smbs_flag_if.store  f
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // A bit drops only when cleared and not set in the same cycle.
    always_comb begin
        q_nxt = (q_r & ~f.clr) | f.set;
    end

    // The flags hold their state while the clock enable is low.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q_r <= '0;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end

    assign f.q = q_r;
endmodule
`default_nettype wire

// ---- smbs_sync.sv ----
// Three-stage synchroniser that passes a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module smbs_sync #(
    parameter int         W   = 2,
    parameter logic [1:0] RST = 2'h3
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;
    logic [W-1:0] q_r;

    // Shift chain; only the second stage reads the first.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ff1_r <= W'(RST);
            ff2_r <= W'(RST);
            ff3_r <= W'(RST);
            q_r   <= W'(RST);
        end else if (ce) begin
            ff1_r <= d;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            if (ff2_r == ff3_r) begin
                q_r <= ff3_r;
            end
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire
